// >>> hw/atb_defs.svh
// Function
// - internal mode starts readings one cycle after entering armed, with no gate edge.
// - internal: endless if unbuffered, else stops at lesser of limit, burst.
// - buffer limit accepts values up to 65,535 readings.
// - abort forces the sequencer to stopped at once from any state.
// - gate edges are detected and start, pause or stop acquisition per mode.
// - external start: go on first valid edge; unbuffered runs until abort.
// - external start buffered: each edge gives a burst; stop at buffer limit.
// - start-stop unbuffered: start on valid edge, stop on opposite edge.
// - start-stop buffered: stop at burst, buffer limit or opposite edge.
// - start-hold forces burst length 1, one reading per edge; buffered stops at limit.
// - windowed: edge starts, burst or opposite edge pauses, edge resumes.
// - windowed repeats forever unbuffered; buffered stops at buffer limit.
// - custom mode configures start, pause, resume and stop independently.
// - buffered readings drain to the host in parallel with capture.
// - each reading carries a sequence count modulo 256.
`ifndef ATB_DEFS_SVH
`define ATB_DEFS_SVH
`define ATB_CNT_W      16
`define ATB_LIMIT_MAX  16'hffff
`define ATB_SEQ_W      8
`define ATB_DATA_W     32
`define ATB_DEPTH_LOG2 4
`define ATB_HOLD_BURST 16'h0001
`endif

// >>> hw/atb_pkg.sv
package atb_pkg;
   typedef enum logic [2:0] {
      ATB_MODE_INTERNAL,
      ATB_MODE_CUSTOM,
      ATB_MODE_EXT_START,
      ATB_MODE_EXT_STARTSTOP,
      ATB_MODE_EXT_STARTHOLD,
      ATB_MODE_EXT_WINDOWED
   } atb_mode_e;
   typedef enum logic [1:0] {
      ATB_SRC_NONE,
      ATB_SRC_EDGE,
      ATB_SRC_OPPOSITE,
      ATB_SRC_INTERNAL
   } atb_src_e;
   typedef struct packed {
      atb_src_e start_src;
      atb_src_e pause_src;
      logic     pause_on_burst;
      atb_src_e resume_src;
      atb_src_e stop_src;
      logic     stop_on_burst;
   } atb_custom_s;
   typedef struct packed {
      logic [7:0]  seq;
      logic [31:0] data;
   } atb_reading_s;
endpackage : atb_pkg

// >>> hw/atb_fifo_mem.sv
`timescale 1ns/1ps
`default_nettype none
module atb_fifo_mem #(
   parameter int WIDTH = 40,
   parameter int AW    = 4
) (
   input  wire logic             clk_in,
   input  wire logic             wr_en_in,
   input  wire logic [AW-1:0]    wr_addr_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic [AW-1:0]    rd_addr_in,
   output logic      [WIDTH-1:0] rd_data_out
);
   logic [WIDTH-1:0] mem [0:(1<<AW)-1];
   always_ff @(posedge clk_in) begin
      if (wr_en_in) begin
         mem[wr_addr_in] <= wr_data_in;
      end
      rd_data_out <= mem[rd_addr_in];
   end
endmodule // atb_fifo_mem
`default_nettype wire

// >>> hw/atb_sequencer.sv
`timescale 1ns/1ps
`default_nettype none
`include "atb_defs.svh"
module atb_sequencer #(
   parameter int CNT_W = `ATB_CNT_W,
   parameter int DW    = `ATB_DATA_W,
   parameter int AW    = `ATB_DEPTH_LOG2
) (
   input  wire logic               clk_in,
   input  wire logic               rst_in,
   input  wire logic               arm_in,
   input  wire logic               abort_in,
   input  wire atb_pkg::atb_mode_e mode_in,
   input  wire atb_pkg::atb_custom_s custom_in,
   input  wire logic               buffered_in,
   input  wire logic               gate_rising_in,
   input  wire logic [CNT_W-1:0]   burst_length_in,
   input  wire logic [CNT_W-1:0]   buffer_limit_in,
   input  wire logic               gate_in,
   input  wire logic               sample_valid_in,
   input  wire logic [DW-1:0]      sample_data_in,
   input  wire logic               ovf_clear_in,
   input  wire logic               host_ready_in,
   output logic                    host_valid_out,
   output atb_pkg::atb_reading_s   host_reading_out,
   output logic                    running_out,
   output logic                    paused_out,
   output logic                    armed_out,
   output logic                    overflow_out,
   output logic [CNT_W-1:0]        taken_out
);
   typedef enum logic [1:0] {
      ST_STOPPED, ST_ARMED, ST_RUN, ST_PAUSED
   } atb_state_e;

   atb_state_e       state, next_state;
   logic             gate_old, next_gate_old;
   logic [CNT_W-1:0] taken, next_taken;
   logic [CNT_W-1:0] in_burst, next_in_burst;
   logic [7:0]       seq, next_seq;
   logic             ovf, next_ovf;
   logic             trig_edge, opp_edge, take;
   logic [CNT_W-1:0] burst_eff, limit_eff;
   atb_pkg::atb_custom_s cfg;

   // fifo state
   logic [AW:0]      wr_ptr, next_wr_ptr, rd_ptr, next_rd_ptr;
   logic             out_valid, next_out_valid;
   logic             full, empty, push, pop_mem;
   logic [DW+7:0]    mem_rd;
   atb_pkg::atb_reading_s out_reg, next_out_reg;
   logic             mem_pend, next_mem_pend;

   // edge detection in chosen polarity
   always_comb begin
      trig_edge = gate_rising_in ? (gate_in & ~gate_old)
                                 : (~gate_in & gate_old);
      opp_edge  = gate_rising_in ? (~gate_in & gate_old)
                                 : (gate_in & ~gate_old);
   end

   // map each predefined mode onto a custom configuration
   always_comb begin
      cfg = custom_in;
      burst_eff = (burst_length_in == '0) ? `ATB_HOLD_BURST : burst_length_in;
      case (mode_in)
         atb_pkg::ATB_MODE_INTERNAL: begin
            cfg = '{atb_pkg::ATB_SRC_INTERNAL, atb_pkg::ATB_SRC_NONE, 1'b0,
                    atb_pkg::ATB_SRC_NONE, atb_pkg::ATB_SRC_NONE,
                    buffered_in};
         end
         atb_pkg::ATB_MODE_EXT_START: begin
            cfg = '{atb_pkg::ATB_SRC_EDGE, atb_pkg::ATB_SRC_NONE, buffered_in,
                    atb_pkg::ATB_SRC_EDGE, atb_pkg::ATB_SRC_NONE,
                    1'b0};
         end
         atb_pkg::ATB_MODE_EXT_STARTSTOP: begin
            cfg = '{atb_pkg::ATB_SRC_EDGE, atb_pkg::ATB_SRC_NONE, 1'b0,
                    atb_pkg::ATB_SRC_NONE, atb_pkg::ATB_SRC_OPPOSITE,
                    buffered_in};
         end
         atb_pkg::ATB_MODE_EXT_STARTHOLD: begin
            burst_eff = `ATB_HOLD_BURST;
            cfg = '{atb_pkg::ATB_SRC_EDGE, atb_pkg::ATB_SRC_NONE, 1'b1,
                    atb_pkg::ATB_SRC_EDGE, atb_pkg::ATB_SRC_NONE, 1'b0};
         end
         atb_pkg::ATB_MODE_EXT_WINDOWED: begin
            cfg = '{atb_pkg::ATB_SRC_EDGE, atb_pkg::ATB_SRC_OPPOSITE, 1'b1,
                    atb_pkg::ATB_SRC_EDGE, atb_pkg::ATB_SRC_NONE,
                    1'b0};
         end
         default: cfg = custom_in;
      endcase
      // limit register is 16 bits, so 65,535 is the ceiling
      limit_eff = (buffer_limit_in > `ATB_LIMIT_MAX) ? `ATB_LIMIT_MAX
                                                     : buffer_limit_in;
   end

   function automatic logic src_hit(input atb_pkg::atb_src_e s,
                                    input logic te, input logic oe);
      case (s)
         atb_pkg::ATB_SRC_EDGE:     src_hit = te;
         atb_pkg::ATB_SRC_OPPOSITE: src_hit = oe;
         atb_pkg::ATB_SRC_INTERNAL: src_hit = 1'b1;
         default:                   src_hit = 1'b0;
      endcase
   endfunction

   assign take = (state == ST_RUN) && sample_valid_in;

   always_comb begin
      next_state    = state;
      next_gate_old = gate_in;
      next_taken    = taken;
      next_in_burst = in_burst;
      next_seq      = seq;
      case (state)
         ST_STOPPED: begin
            if (arm_in) begin
               next_taken    = '0;
               next_in_burst = '0;
               next_seq      = '0;
               next_state    = ST_ARMED;
            end
         end
         ST_ARMED: begin
            if (src_hit(cfg.start_src, trig_edge, opp_edge)) begin
               next_state = ST_RUN;
            end
         end
         ST_RUN: begin
            if (take) begin
               next_taken    = taken + 1'b1;
               next_in_burst = in_burst + 1'b1;
               next_seq      = seq + 8'h01;
            end
            if (buffered_in && take && (taken + 1'b1 >= limit_eff)) begin
               next_state = ST_STOPPED;
            end else if (cfg.stop_on_burst && take
                         && (in_burst + 1'b1 >= burst_eff)) begin
               next_state = ST_STOPPED;
            end else if (src_hit(cfg.stop_src, trig_edge, opp_edge)) begin
               next_state = ST_STOPPED;
            end else if ((cfg.pause_on_burst && take
                          && (in_burst + 1'b1 >= burst_eff))
                         || src_hit(cfg.pause_src, trig_edge, opp_edge)) begin
               next_state = ST_PAUSED;
            end
         end
         ST_PAUSED: begin
            if (src_hit(cfg.stop_src, trig_edge, opp_edge)) begin
               next_state = ST_STOPPED;
            end else if (src_hit(cfg.resume_src, trig_edge, opp_edge)) begin
               next_in_burst = '0;
               next_state    = ST_RUN;
            end
         end
         default: next_state = ST_STOPPED;
      endcase
      if (abort_in) begin
         next_state = ST_STOPPED;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         state    <= ST_STOPPED;
         gate_old <= gate_in; // follow the pin so an idle-high gate gives no edge
         taken    <= '0;
         in_burst <= '0;
         seq      <= 8'h00;
      end else begin
         state    <= next_state;
         gate_old <= next_gate_old;
         taken    <= next_taken;
         in_burst <= next_in_burst;
         seq      <= next_seq;
      end
   end

   // reading buffer drained to host while capturing
   assign full    = (wr_ptr[AW] != rd_ptr[AW])
                    && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
   assign empty   = (wr_ptr == rd_ptr);
   assign push    = take && !full;
   assign pop_mem = !empty && !mem_pend
                    && (!out_valid || host_ready_in);

   always_comb begin
      next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr    = pop_mem ? rd_ptr + 1'b1 : rd_ptr;
      next_mem_pend  = pop_mem;
      next_out_valid = out_valid;
      next_out_reg   = out_reg;
      if (out_valid && host_ready_in) begin
         next_out_valid = 1'b0;
      end
      if (mem_pend) begin
         next_out_valid = 1'b1;
         next_out_reg   = mem_rd;
      end
      // set wins over clear
      next_ovf = ovf;
      if (ovf_clear_in) begin
         next_ovf = 1'b0;
      end
      if (take && full) begin
         next_ovf = 1'b1;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         wr_ptr    <= '0;
         rd_ptr    <= '0;
         mem_pend  <= 1'b0;
         out_valid <= 1'b0;
         out_reg   <= '0;
         ovf       <= 1'b0;
      end else begin
         wr_ptr    <= next_wr_ptr;
         rd_ptr    <= next_rd_ptr;
         mem_pend  <= next_mem_pend;
         out_valid <= next_out_valid;
         out_reg   <= next_out_reg;
         ovf       <= next_ovf;
      end
   end

   atb_fifo_mem #(
      .WIDTH (DW + 8),
      .AW    (AW)
   ) u_mem (
      .clk_in      (clk_in),
      .wr_en_in    (push),
      .wr_addr_in  (wr_ptr[AW-1:0]),
      .wr_data_in  ({seq, sample_data_in}),
      .rd_addr_in  (rd_ptr[AW-1:0]),
      .rd_data_out (mem_rd)
   );

   // mem_pend only rises when out slot will be free, so no loss
   assign host_valid_out   = out_valid;
   assign host_reading_out = out_reg;
   assign running_out      = (state == ST_RUN);
   assign paused_out       = (state == ST_PAUSED);
   assign armed_out        = (state == ST_ARMED);
   assign overflow_out     = ovf;
   assign taken_out        = taken;
endmodule // atb_sequencer
`default_nettype wire

// >>> test/atb_chk.sv
`timescale 1ns/1ps
`default_nettype none
module atb_chk #(
   parameter int CNT_W = 16
) (
   input wire logic                  clk_in,
   input wire logic                  rst_in,
   input wire logic                  abort_in,
   input wire atb_pkg::atb_mode_e    mode_in,
   input wire logic                  buffered_in,
   input wire logic                  gate_rising_in,
   input wire logic [CNT_W-1:0]      buffer_limit_in,
   input wire logic                  gate_in,
   input wire logic                  sample_valid_in,
   input wire logic                  ovf_clear_in,
   input wire logic                  host_ready_in,
   input wire logic                  host_valid_out,
   input wire atb_pkg::atb_reading_s host_reading_out,
   input wire logic                  running_out,
   input wire logic                  paused_out,
   input wire logic                  armed_out,
   input wire logic                  overflow_out,
   input wire logic [CNT_W-1:0]      taken_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (rst_in);
   logic gate_old;
   always_ff @(posedge clk_in) gate_old <= gate_in;
   wire stopped = !running_out && !paused_out && !armed_out;
   wire trig = gate_in != gate_old && gate_in == gate_rising_in;
   wire opp = gate_in != gate_old && gate_in != gate_rising_in;
   a_abort_stop: assert property (abort_in |=> stopped)
      else $error("abort left the sequencer active");
   a_internal_run: assert property (armed_out && !abort_in &&
      mode_in == atb_pkg::ATB_MODE_INTERNAL |=> running_out)
      else $error("internal mode did not start");
   a_edge_start: assert property (armed_out && trig && !abort_in &&
      mode_in == atb_pkg::ATB_MODE_EXT_START |=> running_out)
      else $error("trigger edge did not start");
   a_opp_stop: assert property (running_out && opp && !abort_in &&
      mode_in == atb_pkg::ATB_MODE_EXT_STARTSTOP |=> stopped)
      else $error("opposite edge did not stop");
   a_window_pause: assert property (opp && running_out &&
      !abort_in && !sample_valid_in &&
      mode_in == atb_pkg::ATB_MODE_EXT_WINDOWED |=> paused_out)
      else $error("opposite edge did not pause the window");
   a_hold_once: assert property (running_out && sample_valid_in &&
      mode_in == atb_pkg::ATB_MODE_EXT_STARTHOLD |-> ##[1:2] !running_out)
      else $error("hold mode took more than one reading");
   a_limit_stop: assert property (running_out && buffered_in &&
      taken_out == buffer_limit_in && taken_out != 0 |=> !running_out)
      else $error("run went past the buffer limit");
   a_ovf_sticky: assert property (overflow_out && !ovf_clear_in
      |=> overflow_out) else $error("overflow flag dropped");
   a_valid_hold: assert property (host_valid_out && !host_ready_in
      && !abort_in |=> host_valid_out && $stable(host_reading_out))
      else $error("reading changed before acceptance");
   c_paused: cover property (paused_out);
   c_overflow: cover property (overflow_out);
   c_handover: cover property (host_valid_out && host_ready_in);
endmodule // atb_chk
bind atb_sequencer atb_chk #(.CNT_W(CNT_W)) u_chk (
   .clk_in           (clk_in),
   .rst_in           (rst_in),
   .abort_in         (abort_in),
   .mode_in          (mode_in),
   .buffered_in      (buffered_in),
   .gate_rising_in   (gate_rising_in),
   .buffer_limit_in  (buffer_limit_in),
   .gate_in          (gate_in),
   .sample_valid_in  (sample_valid_in),
   .ovf_clear_in     (ovf_clear_in),
   .host_ready_in    (host_ready_in),
   .host_valid_out   (host_valid_out),
   .host_reading_out (host_reading_out),
   .running_out      (running_out),
   .paused_out       (paused_out),
   .armed_out        (armed_out),
   .overflow_out     (overflow_out),
   .taken_out        (taken_out)
);
`default_nettype wire

// >>> test/atb_partner.sv
`timescale 1ns/1ps
`default_nettype none
module atb_partner (
   input  wire logic clk_in,
   input  wire logic stall_in,
   output logic      gate_out,
   output logic      ready_out
);
   int seed = 32'hc17e9b22;
   initial gate_out = 1'b0;
   // host takes readings at a random pace, never while stalled
   always @(negedge clk_in) ready_out <= !stall_in && ($random(seed) & 1);
   task automatic trig(input logic lvl);
      @(negedge clk_in);
      gate_out = lvl;
   endtask
endmodule // atb_partner
`default_nettype wire

// >>> test/tb_acquisition_trigger_buffer_control.sv
`timescale 1ns/1ps
`default_nettype none
module tb_acquisition_trigger_buffer_control;
   logic clk_in = 1'b0, rst_in = 1'b1, arm, abort, bon, sv, clr, stall = 1'b0;
   logic gate, rdy, hv, run, pse, armd, ovf, pol;
   logic [15:0] bl, lim, taken;
   logic [31:0] sd;
   logic [7:0] sq;
   atb_pkg::atb_mode_e mode;
   atb_pkg::atb_custom_s cus;
   atb_pkg::atb_reading_s rd;
   atb_pkg::atb_reading_s q[$];
   int bad_count = 0, checks = 0, seed = 32'hc17e9b22, n;
   always #20 clk_in = ~clk_in;
   atb_partner p (.clk_in, .stall_in(stall), .gate_out(gate),
      .ready_out(rdy));
   atb_sequencer DUT (.clk_in, .rst_in, .arm_in(arm), .abort_in(abort),
      .mode_in(mode), .custom_in(cus), .buffered_in(bon),
      .gate_rising_in(pol), .burst_length_in(bl), .buffer_limit_in(lim),
      .gate_in(gate), .sample_valid_in(sv), .sample_data_in(sd),
      .ovf_clear_in(clr), .host_ready_in(rdy), .host_valid_out(hv),
      .host_reading_out(rd), .running_out(run), .paused_out(pse),
      .armed_out(armd), .overflow_out(ovf), .taken_out(taken));
   task automatic chk(input string nm, input logic [39:0] e, g);
      checks++;
      if (g !== e) begin
         bad_count++;
         $display("unexpected %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, bad_count);
      if (bad_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge clk_in) begin
      if (hv === 1'b1 && rdy === 1'b1) begin
         if (q.size() > 0) begin
            chk("reading", q.pop_front(), rd);
         end else begin
            bad_count++;
            $display("unexpected reading exp none got %h", rd);
         end
      end
   end
   task automatic cyc(input int k);
      repeat (k) @(negedge clk_in);
   endtask
   task automatic start(input atb_pkg::atb_mode_e m, input logic b,
                        input logic [15:0] bst, l);
      mode = m;
      bon = b;
      bl = bst;
      lim = l;
      sq = 8'h00;
      arm = 1'b1;
      cyc(1);
      arm = 1'b0;
   endtask
   task automatic samp(input int k, input logic keep);
      repeat (k) begin
         sd = $random(seed);
         sv = 1'b1;
         if (keep) q.push_back({sq, sd});
         sq += keep;
         cyc(1);
      end
      sv = 1'b0;
   endtask
   task automatic stopit;
      abort = 1'b1;
      cyc(1);
      abort = 1'b0;
      chk("stopped", 3'b000, {run, pse, armd});
   endtask
   initial begin
      {arm, abort, bon, sv, clr, bl, lim, sd, sq} = '0;
      mode = atb_pkg::ATB_MODE_INTERNAL;
      cus = '0;
      pol = 1'b1;
      cus.start_src = atb_pkg::ATB_SRC_EDGE;
      cyc(10);
      rst_in = 1'b0;
      start(atb_pkg::ATB_MODE_INTERNAL, 1'b0, 16'h0004, 16'h0003);
      chk("armed", 1, armd);
      cyc(1);
      chk("run", 1, run);
      samp(10, 1'b1);
      chk("taken", 10, taken);
      cyc(60);
      chk("drained", 0, q.size());
      stopit;
      $display("test internal stream done");
      for (n = 0; n < 2; n++) begin
         start(atb_pkg::ATB_MODE_INTERNAL, 1'b1, n ? 16'h3 : 16'h8,
               n ? 16'h9 : 16'h5);
         cyc(1);
         samp(n ? 3 : 5, 1'b1);
         cyc(2);
         chk("stop", 0, run);
         samp(2, 1'b0);
         chk("count", n ? 3 : 5, taken);
         cyc(30);
         stopit;
      end
      $display("test internal buffered done");
      for (n = 1; n < 6; n++) begin
         start(atb_pkg::atb_mode_e'(n), 1'b0, 16'h0002, 16'h0001);
         cyc(3);
         chk("idle", 0, run);
         p.trig(1'b1);
         cyc(1);
         chk("start", 1, run);
         if (n == 2) samp(3, 1'b1);
         if (n == 2) chk("keep", 1, run);
         if (n == 3 || n == 5) p.trig(1'b0);
         if (n == 3 || n == 5) cyc(1);
         if (n == 3) chk("opp", 0, run);
         if (n == 5) chk("pause", 1, pse);
         if (n == 5) p.trig(1'b1);
         if (n == 5) cyc(1);
         if (n == 5) chk("resume", 1, run);
         if (n == 4) samp(1, 1'b1);
         if (n == 4) chk("hold", 0, run);
         stopit;
         p.trig(1'b0);
         cyc(20);
      end
      $display("test gate modes done");
      for (n = 2; n < 6; n += 3) begin
         start(atb_pkg::atb_mode_e'(n), 1'b1, 16'h0002, 16'h0004);
         p.trig(1'b1);
         cyc(1);
         samp(2, 1'b1);
         chk("burst pause", 1, pse);
         p.trig(1'b0);
         p.trig(1'b1);
         cyc(1);
         chk("burst resume", 1, run);
         samp(2, 1'b1);
         chk("limit stop", 3'b000, {run, pse, armd});
         chk("limit count", 4, taken);
         p.trig(1'b0);
         cyc(20);
      end
      pol = 1'b0;
      start(atb_pkg::ATB_MODE_EXT_STARTSTOP, 1'b0, 16'h0002, 16'h0001);
      p.trig(1'b1);
      cyc(1);
      chk("rise ignored", 0, run);
      p.trig(1'b0);
      cyc(1);
      chk("fall start", 1, run);
      p.trig(1'b1);
      cyc(1);
      chk("rise stop", 0, run);
      p.trig(1'b0);
      pol = 1'b1;
      cyc(20);
      chk("drained", 0, q.size());
      $display("test buffered gate and polarity done");
      stall = 1'b1;
      start(atb_pkg::ATB_MODE_INTERNAL, 1'b0, 16'h0001, 16'h0001);
      cyc(1);
      samp(24, 1'b0);
      chk("ovf", 1, ovf);
      clr = 1'b1;
      cyc(1);
      clr = 1'b0;
      chk("ovf clear", 0, ovf);
      clr = 1'b1;
      samp(1, 1'b0);
      clr = 1'b0;
      chk("ovf set wins", 1, ovf);
      stopit;
      $display("test overflow done");
      stop_test;
   end
   initial begin
      #120000;
      bad_count++;
      $display("watchdog expired");
      stop_test;
   end
endmodule // tb_acquisition_trigger_buffer_control
`default_nettype wire
